//--- core/mvdf_bin2bcd.sv
// sequential binary to bcd converter (shift and add three)
// assumes start only while idle; one bit per enabled clock
`timescale 1ns/1ps
`default_nettype none
`include "mvdf_consts.svh"

module mvdf_bin2bcd #(
   parameter int IN_W = `MVDF_VAL_W,
   parameter int DIGITS = `MVDF_BCD_DIGITS
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // request
   input wire logic start_i,
   input wire logic [IN_W-1:0] bin_i,
   // result
   output logic busy_o,
   output logic done_o,
   output logic [4*DIGITS-1:0] bcd_o
);

   localparam int CNT_W = $clog2(IN_W + 1);

   logic [IN_W-1:0] sh_reg;
   logic [4*DIGITS-1:0] acc_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [4*DIGITS-1:0] adj;
   wire logic last;

   // correct each digit before the shift
   genvar g;
   generate
      for (g = 0; g < DIGITS; g++) begin : g_adj
         wire logic [3:0] dig = acc_reg[4*g +: 4];
         assign adj[4*g +: 4] = (dig >= `MVDF_BCD_LIMIT) ? dig + `MVDF_BCD_ADJ : dig;
      end
   endgenerate

   assign last = (cnt_reg == CNT_W'(1));

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sh_reg <= '0;
         acc_reg <= '0;
         cnt_reg <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         bcd_o <= '0;
      end else if (ce_i) begin
         done_o <= 1'b0;
         if (start_i && !busy_o) begin
            sh_reg <= bin_i;
            acc_reg <= '0;
            cnt_reg <= CNT_W'(IN_W);
            busy_o <= 1'b1;
         end else if (busy_o) begin
            acc_reg <= {adj[4*DIGITS-2:0], sh_reg[IN_W-1]};
            sh_reg <= {sh_reg[IN_W-2:0], 1'b0};
            cnt_reg <= cnt_reg - CNT_W'(1);
            if (last) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
               bcd_o <= {adj[4*DIGITS-2:0], sh_reg[IN_W-1]};
            end
         end
      end
   end

endmodule

`default_nettype wire

//--- core/mvdf_consts.svh
// constants for the monitor value display formatter
// assumes inclusion by bare name from the package and the design files
`ifndef MVDF_CONSTS_SVH
`define MVDF_CONSTS_SVH

// display geometry
`define MVDF_POSITIONS 5
`define MVDF_SEG_W 7
`define MVDF_VAL_W 32
`define MVDF_HALF_W 16
`define MVDF_BCD_DIGITS 10

// glyph codes: 0..15 are hex digits
`define MVDF_GLYPH_W 5
`define MVDF_GLYPH_HI 5'h10
`define MVDF_GLYPH_LO 5'h11
`define MVDF_GLYPH_BLANK 5'h12

// segment patterns, bit order g f e d c b a
`define MVDF_SEG_0 7'h3F
`define MVDF_SEG_1 7'h06
`define MVDF_SEG_2 7'h5B
`define MVDF_SEG_3 7'h4F
`define MVDF_SEG_4 7'h66
`define MVDF_SEG_5 7'h6D
`define MVDF_SEG_6 7'h7D
`define MVDF_SEG_7 7'h07
`define MVDF_SEG_8 7'h7F
`define MVDF_SEG_9 7'h6F
`define MVDF_SEG_A 7'h77
`define MVDF_SEG_B 7'h7C
`define MVDF_SEG_C 7'h39
`define MVDF_SEG_D 7'h5E
`define MVDF_SEG_E 7'h79
`define MVDF_SEG_F 7'h71
`define MVDF_SEG_H 7'h74
`define MVDF_SEG_L 7'h38
`define MVDF_SEG_OFF 7'h00

// decimal-point patterns across the five positions
`define MVDF_DP_NONE 5'h00
`define MVDF_DP_ALL 5'h1F
`define MVDF_DP_UPPER 5'h02
`define MVDF_DP_LOWER 5'h01

// double-dabble correction
`define MVDF_BCD_LIMIT 4'h5
`define MVDF_BCD_ADJ 4'h3

`endif

//--- core/mvdf_formatter.sv
// five-digit seven-segment formatter for monitor and parameter values
// assumes a value source that strobes update_i with its fixed format
// Overview of operation
// - 16-bit hex shows four digits, no prefix
// - 16-bit decimal converted to five decimal digits
// - 32-bit decimal split, upper/lower marked by points; negative ones light all points instead
// - 32-bit hex halves prefixed by h or L
// - negative decimal lights decimal points, no minus
// - hex never marks negative values
// - 32-bit monitor values, key selects shown half
// - format fixed per parameter, operator cannot change
// - same formatting in monitor and edit modes
`timescale 1ns/1ps
`default_nettype none
`include "mvdf_consts.svh"

module mvdf_formatter #(
   parameter int VAL_W = `MVDF_VAL_W,
   parameter int POS = `MVDF_POSITIONS
) (
   // clock, reset, enable
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   // value source
   input wire logic update_i,
   input wire logic [VAL_W-1:0] value_i,
   input wire logic wide_i,
   input wire logic hex_i,
   input wire logic signed_i,
   // front-panel key and mode
   input wire logic half_hi_i,
   input wire logic edit_mode_i,
   // display drive
   output logic [POS*`MVDF_SEG_W-1:0] seg_o,
   output logic [POS-1:0] dp_o,
   output logic busy_o,
   output logic valid_o,
   output logic edit_mode_o
);

   localparam int HW = `MVDF_HALF_W;
   localparam int DIG = `MVDF_BCD_DIGITS;

   // reset release
   logic rst_s1_reg;
   logic rst_s2_reg;

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end

   // release is synchronised; assertion still acts at once
   wire logic rst_n = rst_s2_reg;

   // latched value and its fixed format
   mvdf_pkg::mvdf_state_t state_reg;
   mvdf_pkg::mvdf_state_t state_next;
   logic [VAL_W-1:0] val_reg;
   logic wide_reg;
   logic hex_reg;
   logic neg_reg;

   // sign and magnitude of the incoming value
   wire logic [HW-1:0] v16 = value_i[HW-1:0];
   wire logic neg16 = signed_i && v16[HW-1];
   wire logic neg32 = signed_i && value_i[VAL_W-1];
   // most negative 16-bit value still fits as an unsigned magnitude
   wire logic [HW-1:0] mag16 = neg16 ? HW'(-v16) : v16;
   wire logic [VAL_W-1:0] mag32 = neg32 ? VAL_W'(-value_i) : value_i;
   wire logic [VAL_W-1:0] mag = wide_i ? mag32 : {{(VAL_W-HW){1'b0}}, mag16};
   wire logic neg_in = !hex_i && (wide_i ? neg32 : neg16);

   // an update during conversion is dropped, not queued
   wire logic take = update_i && (state_reg != mvdf_pkg::MVDF_CONV);
   wire logic conv_busy;
   wire logic conv_done;
   wire logic [4*DIG-1:0] bcd;

   // conversion runs for hex too; costs VAL_W cycles but keeps one path
   mvdf_bin2bcd #(
      .IN_W(VAL_W),
      .DIGITS(DIG)
   ) u_bcd (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n),
      .ce_i(ce_i),
      .start_i(take),
      .bin_i(mag),
      .busy_o(conv_busy),
      .done_o(conv_done),
      .bcd_o(bcd)
   );

   // default pulls an upset state code back to idle
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         mvdf_pkg::MVDF_IDLE: if (take) state_next = mvdf_pkg::MVDF_CONV;
         mvdf_pkg::MVDF_CONV: if (conv_done) state_next = mvdf_pkg::MVDF_SHOW;
         mvdf_pkg::MVDF_SHOW: if (take) state_next = mvdf_pkg::MVDF_CONV;
         default: state_next = mvdf_pkg::MVDF_IDLE;
      endcase
   end

   // format is latched with the value only; no key path touches it
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= mvdf_pkg::MVDF_IDLE;
         val_reg <= '0;
         wide_reg <= 1'b0;
         hex_reg <= 1'b0;
         neg_reg <= 1'b0;
      end else if (ce_i) begin
         state_reg <= state_next;
         if (take) begin
            val_reg <= value_i;
            wide_reg <= wide_i;
            hex_reg <= hex_i;
            neg_reg <= neg_in;
         end
      end
   end

   // view decode shared by the hex and decimal paths
   wire logic show_hi = wide_reg && half_hi_i;
   wire logic show_now = (state_reg == mvdf_pkg::MVDF_SHOW);
   wire logic show_soon = (state_next == mvdf_pkg::MVDF_SHOW);
   wire logic neg_dec = !hex_reg && neg_reg;

   // view selection
   // the key acts on the stored value, so a half swap needs no reconversion
   wire logic [HW-1:0] hex_half = show_hi ?
      val_reg[VAL_W-1:HW] : val_reg[HW-1:0];
   wire logic [4*POS-1:0] dec_view = show_hi ?
      bcd[4*DIG-1:4*POS] : bcd[4*POS-1:0];
   // 16-bit hex leaves the leftmost position dark
   wire mvdf_pkg::mvdf_glyph_t hex_lead = !wide_reg ? `MVDF_GLYPH_BLANK :
      (half_hi_i ? `MVDF_GLYPH_HI : `MVDF_GLYPH_LO);
   wire logic [POS-1:0] half_mark = !wide_reg ? `MVDF_DP_NONE :
      (half_hi_i ? `MVDF_DP_UPPER : `MVDF_DP_LOWER);
   // sign marks win over half marks; a negative wide value loses its half cue
   wire logic [POS-1:0] dp_next = hex_reg ? `MVDF_DP_NONE :
      (neg_dec ? `MVDF_DP_ALL : half_mark);

   // unknown glyph codes stay dark

   function automatic logic [`MVDF_SEG_W-1:0] glyph_seg(input mvdf_pkg::mvdf_glyph_t g);
      logic [`MVDF_SEG_W-1:0] s;
      s = `MVDF_SEG_OFF;
      case (g)
         5'h00: s = `MVDF_SEG_0;
         5'h01: s = `MVDF_SEG_1;
         5'h02: s = `MVDF_SEG_2;
         5'h03: s = `MVDF_SEG_3;
         5'h04: s = `MVDF_SEG_4;
         5'h05: s = `MVDF_SEG_5;
         5'h06: s = `MVDF_SEG_6;
         5'h07: s = `MVDF_SEG_7;
         5'h08: s = `MVDF_SEG_8;
         5'h09: s = `MVDF_SEG_9;
         5'h0A: s = `MVDF_SEG_A;
         5'h0B: s = `MVDF_SEG_B;
         5'h0C: s = `MVDF_SEG_C;
         5'h0D: s = `MVDF_SEG_D;
         5'h0E: s = `MVDF_SEG_E;
         5'h0F: s = `MVDF_SEG_F;
         `MVDF_GLYPH_HI: s = `MVDF_SEG_H;
         `MVDF_GLYPH_LO: s = `MVDF_SEG_L;
         default: s = `MVDF_SEG_OFF;
      endcase
      return s;
   endfunction

   // one glyph per position; leading zeros kept in decimal
   // leftmost position carries the hex prefix (dark for 16-bit hex) or the top decimal digit
   logic [POS*`MVDF_SEG_W-1:0] seg_next;
   genvar p;
   generate
      for (p = 0; p < POS; p++) begin : g_pos
         mvdf_pkg::mvdf_glyph_t gl;
         if (p == POS - 1) begin : g_lead
            assign gl = hex_reg ? hex_lead : {1'b0, dec_view[4*p +: 4]};
         end else begin : g_body
            assign gl = hex_reg ? {1'b0, hex_half[4*p +: 4]} : {1'b0, dec_view[4*p +: 4]};
         end
         assign seg_next[`MVDF_SEG_W*p +: `MVDF_SEG_W] = glyph_seg(gl);
      end
   endgenerate

   wire logic busy_next = conv_busy || take;

   // edit and monitor share this path unchanged; mode only passes through
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         seg_o <= '0;
         dp_o <= '0;
         busy_o <= 1'b0;
         valid_o <= 1'b0;
         edit_mode_o <= 1'b0;
      end else if (ce_i) begin
         busy_o <= busy_next;
         // valid rises with the show state, one edge before the first render
         valid_o <= show_soon;
         edit_mode_o <= edit_mode_i;
         if (show_now) begin
            seg_o <= seg_next;
            dp_o <= dp_next;
         end
      end
   end

endmodule

`default_nettype wire

//--- core/mvdf_pkg.sv
// types for the monitor value display formatter
// assumes mvdf_consts.svh is on the include path
`include "mvdf_consts.svh"

package mvdf_pkg;

   // gray codes along idle -> convert -> show
   typedef enum logic [1:0] {
      MVDF_IDLE = 2'h0,
      MVDF_CONV = 2'h1,
      MVDF_SHOW = 2'h3
   } mvdf_state_t;

   typedef logic [`MVDF_GLYPH_W-1:0] mvdf_glyph_t;

endpackage

//--- tb/mvdf_formatter_assertions.sv
// port checker for the display formatter
// assumes ce_i high during conversion and inputs held until the display settles
`timescale 1ns/1ps
`default_nettype none
`include "mvdf_consts.svh"

module mvdf_formatter_assertions #(
   parameter int VAL_W = 32,
   parameter int POS = 5
) (
   // watched ports
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic update_i,
   input wire logic [VAL_W-1:0] value_i,
   input wire logic wide_i,
   input wire logic hex_i,
   input wire logic signed_i,
   input wire logic half_hi_i,
   input wire logic edit_mode_i,
   input wire logic [POS*`MVDF_SEG_W-1:0] seg_o,
   input wire logic [POS-1:0] dp_o,
   input wire logic busy_o,
   input wire logic valid_o,
   input wire logic edit_mode_o
);
   wire take = ce_i && update_i && !busy_o;
   wire neg = signed_i && (wide_i ? value_i[VAL_W-1] : value_i[15]);
   wire [6:0] left = seg_o[POS*`MVDF_SEG_W-1 -: `MVDF_SEG_W];
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   take_busy_a: assert property (take |-> ##[1:2] (busy_o && !valid_o))
      else $error("busy not raised after take");
   conv_time_a: assert property (take |-> ##2 (!valid_o) [*8] ##[25:26] valid_o)
      else $error("valid not at conversion time");
   hex_nodp_a: assert property (take && hex_i |-> ##38 dp_o == `MVDF_DP_NONE)
      else $error("hex shows decimal points");
   neg_dp_a: assert property (take && !hex_i && neg |-> ##38 dp_o == `MVDF_DP_ALL)
      else $error("negative decimal not marked");
   hex_blank_a: assert property (take && hex_i && !wide_i |-> ##38 left == `MVDF_SEG_OFF)
      else $error("short hex has a prefix");
   hex_prefix_a: assert property (take && hex_i && wide_i |->
      ##38 left == (half_hi_i ? `MVDF_SEG_H : `MVDF_SEG_L)) else $error("wrong half glyph");
   dec_zero_a: assert property (take && !hex_i && !wide_i && !neg && value_i[15:0] < 16'h2710
      |-> ##38 left == `MVDF_SEG_0) else $error("no leading zero");
   dec_half_a: assert property (take && !hex_i && wide_i && !neg |->
      ##38 dp_o == (half_hi_i ? `MVDF_DP_UPPER : `MVDF_DP_LOWER)) else $error("half mark");
   edit_copy_a: assert property (valid_o |-> edit_mode_o == $past(edit_mode_i))
      else $error("edit mode copy wrong");
endmodule

bind mvdf_formatter mvdf_formatter_assertions #(.VAL_W(VAL_W), .POS(POS)) u_chk (
   .core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .update_i(update_i),
   .value_i(value_i), .wide_i(wide_i), .hex_i(hex_i), .signed_i(signed_i),
   .half_hi_i(half_hi_i), .edit_mode_i(edit_mode_i), .seg_o(seg_o), .dp_o(dp_o),
   .busy_o(busy_o), .valid_o(valid_o), .edit_mode_o(edit_mode_o));

`default_nettype wire

//--- tb/mvdf_panel_model.sv
// front-panel model: operator key and mode switch seen by the formatter
// assumes keys change only at clock edges, like a debounced panel
`timescale 1ns/1ps
`default_nettype none

module mvdf_panel_model (
   // clock
   input wire logic core_clk_i,
   // operator actions
   input wire logic key_hi_i,
   input wire logic edit_i,
   // to formatter
   output logic half_hi_o,
   output logic edit_mode_o
);
   logic hi_reg = 1'b0;
   logic edit_reg = 1'b0;
   // one flop, as a debounced key would lag
   always @(posedge core_clk_i) begin
      hi_reg <= key_hi_i;
      edit_reg <= edit_i;
   end
   assign half_hi_o = hi_reg;
   assign edit_mode_o = edit_reg;
endmodule

`default_nettype wire

//--- tb/test_monitor_value_display_formatter.sv
// self-checking bench for the display formatter
// assumes the panel model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "mvdf_consts.svh"

module test_monitor_value_display_formatter;
   logic core_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic update_i = 1'b0;
   logic wide_i = 1'b0;
   logic hex_i = 1'b0;
   logic signed_i = 1'b0;
   logic key_hi = 1'b0;
   logic edit = 1'b0;
   logic ce = 1'b1;
   logic [31:0] value_i = 32'h0;
   logic half_hi, edit_mode, busy_o, valid_o, edit_mode_o;
   logic [34:0] seg_o;
   logic [4:0] dp_o;
   int err_count = 0;
   int tests_run = 0;
   logic [6:0] st [0:18] = '{`MVDF_SEG_0, `MVDF_SEG_1, `MVDF_SEG_2, `MVDF_SEG_3, `MVDF_SEG_4,
      `MVDF_SEG_5, `MVDF_SEG_6, `MVDF_SEG_7, `MVDF_SEG_8, `MVDF_SEG_9, `MVDF_SEG_A, `MVDF_SEG_B,
      `MVDF_SEG_C, `MVDF_SEG_D, `MVDF_SEG_E, `MVDF_SEG_F, `MVDF_SEG_H, `MVDF_SEG_L, `MVDF_SEG_OFF};
   always #12.5 core_clk_i = ~core_clk_i;
   mvdf_panel_model u_panel (.core_clk_i(core_clk_i), .key_hi_i(key_hi), .edit_i(edit),
      .half_hi_o(half_hi), .edit_mode_o(edit_mode));
   mvdf_formatter u_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(ce),
      .update_i(update_i), .value_i(value_i), .wide_i(wide_i), .hex_i(hex_i),
      .signed_i(signed_i), .half_hi_i(half_hi), .edit_mode_i(edit_mode), .seg_o(seg_o),
      .dp_o(dp_o), .busy_o(busy_o), .valid_o(valid_o), .edit_mode_o(edit_mode_o));
   task automatic summarize();
      $display("mismatches %0d of %0d checks", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [34:0] got, input logic [34:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [34:0] f5(input logic [4:0] a, b, c, d, e);
      return {st[a], st[b], st[c], st[d], st[e]};
   endfunction
   task automatic settle();
      int n;
      n = 0;
      #1;
      while (valid_o !== 1'b1 && n < 60) begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
      if (n == 60) begin
         chk(35'h1, 35'h0);
         summarize();
      end
      chk(valid_o, 1'b1);
      chk(busy_o, 1'b0);
      repeat (4) @(posedge core_clk_i);
      #1;
   endtask
   task automatic go(input logic [31:0] v, input logic w, h, s);
      @(posedge core_clk_i);
      update_i <= 1'b1;
      value_i <= v;
      wide_i <= w;
      hex_i <= h;
      signed_i <= s;
      @(posedge core_clk_i);
      update_i <= 1'b0;
      // format is latched; flipping it must not alter the view
      hex_i <= ~h;
      repeat (2) @(posedge core_clk_i);
      settle();
   endtask
   task automatic key(input logic hi);
      @(posedge core_clk_i);
      key_hi <= hi;
      repeat (3) @(posedge core_clk_i);
      #1;
   endtask
   task automatic t_hex16();
      go(32'h0000F234, 1'b0, 1'b1, 1'b1);
      chk(seg_o, f5(5'h12, 5'hF, 5'h2, 5'h3, 5'h4));
      chk(dp_o, `MVDF_DP_NONE);
   endtask
   task automatic t_dec16();
      go(32'h000004D2, 1'b0, 1'b0, 1'b0);
      chk(seg_o, f5(5'h0, 5'h1, 5'h2, 5'h3, 5'h4));
      chk(dp_o, `MVDF_DP_NONE);
   endtask
   task automatic t_refuse();
      @(posedge core_clk_i);
      update_i <= 1'b1;
      value_i <= 32'h000004D2;
      wide_i <= 1'b0;
      hex_i <= 1'b0;
      signed_i <= 1'b0;
      @(posedge core_clk_i);
      update_i <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      // a second update in mid-conversion must be dropped
      update_i <= 1'b1;
      value_i <= 32'h0000162E;
      hex_i <= 1'b1;
      @(posedge core_clk_i);
      update_i <= 1'b0;
      settle();
      chk(seg_o, f5(5'h0, 5'h1, 5'h2, 5'h3, 5'h4));
      chk(dp_o, `MVDF_DP_NONE);
   endtask
   task automatic t_dec32();
      key(1'b1);
      go(32'h499602D2, 1'b1, 1'b0, 1'b0);
      chk(seg_o, f5(5'h1, 5'h2, 5'h3, 5'h4, 5'h5));
      chk(dp_o, `MVDF_DP_UPPER);
      key(1'b0);
      chk(seg_o, f5(5'h6, 5'h7, 5'h8, 5'h9, 5'h0));
      chk(dp_o, `MVDF_DP_LOWER);
   endtask
   task automatic t_hex32();
      key(1'b1);
      go(32'h12345678, 1'b1, 1'b1, 1'b0);
      chk(seg_o, f5(5'h10, 5'h1, 5'h2, 5'h3, 5'h4));
      chk(dp_o, `MVDF_DP_NONE);
      key(1'b0);
      chk(seg_o, f5(5'h11, 5'h5, 5'h6, 5'h7, 5'h8));
   endtask
   task automatic t_freeze();
      // with the enable low a key press must not reach the display
      @(posedge core_clk_i);
      ce <= 1'b0;
      key(1'b1);
      chk(seg_o, f5(5'h11, 5'h5, 5'h6, 5'h7, 5'h8));
      @(posedge core_clk_i);
      ce <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      #1;
      chk(seg_o, f5(5'h10, 5'h1, 5'h2, 5'h3, 5'h4));
   endtask
   task automatic t_neg();
      @(posedge core_clk_i);
      edit <= 1'b1;
      go(32'h0000CFC7, 1'b0, 1'b0, 1'b1);
      chk(seg_o, f5(5'h1, 5'h2, 5'h3, 5'h4, 5'h5));
      chk(dp_o, `MVDF_DP_ALL);
      chk(edit_mode_o, 1'b1);
   endtask
   initial begin
      repeat (3) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      t_hex16();
      t_dec16();
      t_refuse();
      t_dec32();
      t_hex32();
      t_freeze();
      t_neg();
      summarize();
   end
endmodule

`default_nettype wire
